// file: core/adcrc_map.svh
// Purpose: register offsets, field positions, reset values and timing counts
// Assumes: 32-bit classic wishbone, one aligned word per register
// Notes:   8-bit registers sit in the low byte lane; upper bits read as zero
`ifndef ADCRC_MAP_SVH
`define ADCRC_MAP_SVH

`define ADCRC_OFS_STATUS      8'h00
`define ADCRC_OFS_RES_HIGH    8'h04
`define ADCRC_OFS_RES_LOW     8'h08
`define ADCRC_OFS_CLK_CFG     8'h0C

`define ADCRC_STS_DONE_BIT    7
`define ADCRC_STS_IRQEN_BIT   6
`define ADCRC_STS_CONT_BIT    5
`define ADCRC_CH_OFF          5'h1F

`define ADCRC_STATUS_RESET    8'h1F
`define ADCRC_CLK_CFG_RESET   8'h00

`define ADCRC_MODE_8BIT       2'h0
`define ADCRC_MODE_10BIT      2'h1
`define ADCRC_MODE_RESERVED   2'h2
`define ADCRC_MODE_10BIT_EXT  2'h3

`define ADCRC_SAMPLE_SHORT_X10 35
`define ADCRC_SAMPLE_LONG_X10  235
`define ADCRC_SAMPLE_SHORT_CYC ((`ADCRC_SAMPLE_SHORT_X10 + 9) / 10)
`define ADCRC_SAMPLE_LONG_CYC  ((`ADCRC_SAMPLE_LONG_X10 + 9) / 10)

`define ADCRC_SAR_BITS        11
`define ADCRC_BUS_CLK_MHZ     25

`endif

// file: core/adcrc_pkg.sv
// Purpose: shared types of the converter control block
// Assumes: field layout constants come from adcrc_map.svh
// Notes:   struct layouts match the register bit order, msb first
package adcrc_pkg;

  typedef struct packed {
    logic       low_power_config;
    logic [1:0] clock_divide_ratio;
    logic       input_clock_select;
    logic [1:0] mode;
    logic       long_sample_select;
    logic       async_clock_enable;
  } adcrc_clk_cfg_t;

  typedef struct packed {
    logic       conv_irq_enable;
    logic       continuous_convert;
    logic [4:0] channel_select;
  } adcrc_ctrl_t;

  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
  } adcrc_result_t;

  typedef enum logic [1:0] {
    ADCRC_IDLE,
    ADCRC_SAMPLE,
    ADCRC_CONVERT
  } adcrc_sar_state_t;

endpackage

// file: core/adcrc_clkdiv.sv
// Purpose: derive the converter clock tick from the selected input tick
// Assumes: in_tick is a one-cycle pulse per input clock period
// Notes:   counter restarts while run is low so each conversion starts aligned
`timescale 1ns/1ps
`include "adcrc_map.svh"

module adcrc_clkdiv (
  input  wire logic       clock,
  input  wire logic       resetn,
  input  wire logic       run,
  input  wire logic       in_tick,
  input  wire logic [1:0] clock_divide_ratio,
  output logic            conv_tick
);

  logic [2:0] count;
  logic [2:0] limit;

  // divide by 1, 2, 4 or 8
  function automatic logic [2:0] div_limit(input logic [1:0] code);
    unique case (code)
      2'h0: div_limit = 3'h0;
      2'h1: div_limit = 3'h1;
      2'h2: div_limit = 3'h3;
      2'h3: div_limit = 3'h7;
    endcase
  endfunction

  assign limit = div_limit(clock_divide_ratio);

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      count <= 3'h0;
    end else if (!run) begin
      count <= 3'h0;
    end else if (in_tick) begin
      count <= (count >= limit) ? 3'h0 : count + 3'h1;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      conv_tick <= 1'b0;
    end else begin
      conv_tick <= run && in_tick && (count >= limit);
    end
  end

endmodule

// file: core/adcrc_sar.sv
// Purpose: sample phase and successive approximation sequence
// Assumes: comp_above is high while the input is at or above dac_code
// Notes:   fractional sample times round up to whole converter cycles
`timescale 1ns/1ps
`include "adcrc_map.svh"

module adcrc_sar (
  input  wire logic                       clock,
  input  wire logic                       resetn,
  input  wire logic                       start,
  input  wire logic                       abort,
  input  wire logic                       conv_tick,
  input  wire logic                       long_sample_select,
  input  wire logic                       comp_above,
  output logic [`ADCRC_SAR_BITS-1:0]      dac_code,
  output logic                            sample_enable,
  output logic                            busy,
  output logic                            done,
  output logic [`ADCRC_SAR_BITS-1:0]      raw
);

  adcrc_pkg::adcrc_sar_state_t state;
  logic [4:0]                  sample_count;
  logic [`ADCRC_SAR_BITS-1:0]  trial_bit;
  logic [4:0]                  sample_last;

  localparam logic [4:0] SHORT_LAST = 5'(`ADCRC_SAMPLE_SHORT_CYC - 1);
  localparam logic [4:0] LONG_LAST  = 5'(`ADCRC_SAMPLE_LONG_CYC - 1);

  assign sample_last = long_sample_select ? LONG_LAST : SHORT_LAST;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state         <= adcrc_pkg::ADCRC_IDLE;
      sample_count  <= 5'h00;
      trial_bit     <= '0;
      dac_code      <= '0;
      sample_enable <= 1'b0;
      busy          <= 1'b0;
      done          <= 1'b0;
      raw           <= '0;
    end else begin
      done <= 1'b0;
      if (abort || start) begin
        state         <= start ? adcrc_pkg::ADCRC_SAMPLE : adcrc_pkg::ADCRC_IDLE;
        busy          <= start;
        sample_enable <= start;
        sample_count  <= 5'h00;
        dac_code      <= '0;
      end else if (conv_tick) begin
        unique case (state)
          adcrc_pkg::ADCRC_IDLE: begin
            busy <= 1'b0;
          end
          adcrc_pkg::ADCRC_SAMPLE: begin
            if (sample_count >= sample_last) begin
              state         <= adcrc_pkg::ADCRC_CONVERT;
              sample_enable <= 1'b0;
              trial_bit     <= {1'b1, {(`ADCRC_SAR_BITS-1){1'b0}}};
              dac_code      <= {1'b1, {(`ADCRC_SAR_BITS-1){1'b0}}};
            end else begin
              sample_count <= sample_count + 5'h01;
            end
          end
          adcrc_pkg::ADCRC_CONVERT: begin
            // keep the trial bit only when the input lies at or above it
            if (trial_bit[0]) begin
              raw   <= comp_above ? dac_code : (dac_code & ~trial_bit);
              done  <= 1'b1;
              busy  <= 1'b0;
              state <= adcrc_pkg::ADCRC_IDLE;
            end else begin
              dac_code <= (comp_above ? dac_code : (dac_code & ~trial_bit))
                          | (trial_bit >> 1);
            end
            trial_bit <= trial_bit >> 1;
          end
        endcase
      end
    end
  end

endmodule

// file: core/adcrc_top.sv
// Purpose: converter control with result interlock and clock configuration
// Assumes: classic wishbone slave, analog comparator outside, one bus clock
// Notes:   alternate and asynchronous clocks arrive as bus-clock tick pulses
//
// Contract
// - high result loaded each completion, subject to interlock, unused bits zero
// - 10-bit: high read freezes results until low read
// - completions while frozen are discarded
// - 8-bit mode has no read interlock
// - low result loaded each completion, subject to interlock
// - low-power bit selects reduced-power converter setting
// - converter clock is input divided by 1,2,4,8
// - select bit chooses bus or alternate clock
// - mode field: 8-bit, 10-bit, reserved, external trigger
// - result rounded to selected width, half-LSB error
// - sample lasts 23.5 or 3.5 converter cycles; the code rounds up to 24 or 4
// - async enable: generator runs only while converting
// - async disabled: select bit chooses, stop halts conversion
// - done flag cleared by status write or low read
// - clock config write stops continuous conversion
// - interrupt request cleared by data read or status write
//
// Implementation choices: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps
`include "adcrc_map.svh"

module adcrc_top (
  input  wire logic                   clock,
  input  wire logic                   resetn,
  input  wire logic                   wb_cyc_i,
  input  wire logic                   wb_stb_i,
  input  wire logic                   wb_we_i,
  input  wire logic [7:0]             wb_adr_i,
  input  wire logic [3:0]             wb_sel_i,
  input  wire logic [31:0]            wb_dat_i,
  output logic      [31:0]            wb_dat_o,
  output logic                        wb_ack_o,
  input  wire logic                   comp_above,
  input  wire logic                   ext_trigger,
  input  wire logic                   stop_mode,
  input  wire logic                   alt_clk_tick,
  input  wire logic                   async_clk_tick,
  output logic                        async_gen_enable,
  output logic                        low_power_config,
  output logic                        sample_enable,
  output logic [`ADCRC_SAR_BITS-1:0]  dac_code,
  output logic [4:0]                  channel_select,
  output logic                        conv_irq
);

  adcrc_pkg::adcrc_clk_cfg_t  conv_clock_config;
  adcrc_pkg::adcrc_ctrl_t     ctrl;
  adcrc_pkg::adcrc_result_t   result;
  logic                       conversion_done_flag;
  logic                       interlock;

  logic                       access;
  logic                       wr_lane0;
  logic                       wr_status;
  logic                       wr_clk_cfg;
  logic                       rd_high;
  logic                       rd_low;
  logic [7:0]                 next_rd_byte;

  logic                       in_tick;
  logic                       conv_tick;
  logic                       sar_busy;
  logic                       sar_done;
  logic [`ADCRC_SAR_BITS-1:0] sar_raw;
  logic                       start;
  logic                       abort;
  logic                       stop_halt;
  logic                       channel_on;
  logic                       mode_10bit;
  logic                       transfer;
  logic [9:0]                 rounded;

  // round the 11-bit approximation to 8 or 10 bits, saturating at full scale
  function automatic logic [9:0] round_result(input logic [10:0] raw_code,
                                              input logic        ten_bit);
    logic [11:0] sum;
    sum = 12'h000;
    if (ten_bit) begin
      sum = {1'b0, raw_code} + 12'h001;
      round_result = sum[11] ? 10'h3FF : sum[10:1];
    end else begin
      sum = {1'b0, raw_code} + 12'h004;
      round_result = sum[11] ? 10'h0FF : {2'h0, sum[10:3]};
    end
  endfunction

  // bus decode: every request is answered in the cycle after it is seen
  assign access     = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_lane0   = access && wb_we_i && wb_sel_i[0];
  assign wr_status  = wr_lane0 && (wb_adr_i == `ADCRC_OFS_STATUS);
  assign wr_clk_cfg = wr_lane0 && (wb_adr_i == `ADCRC_OFS_CLK_CFG);
  assign rd_high    = access && !wb_we_i && (wb_adr_i == `ADCRC_OFS_RES_HIGH);
  assign rd_low     = access && !wb_we_i && (wb_adr_i == `ADCRC_OFS_RES_LOW);

  always_comb begin
    next_rd_byte = 8'h00;
    unique case (wb_adr_i)
      `ADCRC_OFS_STATUS:   next_rd_byte = {conversion_done_flag, ctrl};
      `ADCRC_OFS_RES_HIGH: next_rd_byte = result.high;
      `ADCRC_OFS_RES_LOW:  next_rd_byte = result.low;
      `ADCRC_OFS_CLK_CFG:  next_rd_byte = conv_clock_config;
      default:             next_rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= access;
      if (access) begin
        wb_dat_o <= wb_we_i ? 32'h0000_0000 : {24'h00_0000, next_rd_byte};
      end
    end
  end

  // clock configuration register
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      conv_clock_config <= `ADCRC_CLK_CFG_RESET;
    end else if (wr_clk_cfg) begin
      conv_clock_config <= wb_dat_i[7:0];
    end
  end

  assign mode_10bit = conv_clock_config.mode != `ADCRC_MODE_8BIT;
  assign channel_on = ctrl.channel_select != `ADCRC_CH_OFF;
  // stop without the asynchronous clock aborts conversion and clears continuous mode
  assign stop_halt  = stop_mode && !conv_clock_config.async_clock_enable;

  // status and control register
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ctrl <= 7'(`ADCRC_STATUS_RESET);
    end else if (wr_status) begin
      ctrl <= wb_dat_i[6:0];
    end else if (wr_clk_cfg || stop_halt) begin
      ctrl.continuous_convert <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      channel_select <= `ADCRC_CH_OFF;
    end else begin
      channel_select <= ctrl.channel_select;
    end
  end

  // conversion start and abort
  always_comb begin
    start = 1'b0;
    unique case (conv_clock_config.mode)
      `ADCRC_MODE_8BIT, `ADCRC_MODE_10BIT: begin
        start = wr_status && (wb_dat_i[4:0] != `ADCRC_CH_OFF);
        if (sar_done && ctrl.continuous_convert && channel_on && !stop_halt) begin
          start = 1'b1;
        end
      end
      `ADCRC_MODE_10BIT_EXT: begin
        start = ext_trigger && channel_on && !sar_busy && !stop_halt && !wr_status;
      end
      `ADCRC_MODE_RESERVED: begin
        start = 1'b0;
      end
    endcase
  end

  assign abort = (wr_status || stop_halt) && !start;

  // input clock selection; async clock has priority when enabled
  always_comb begin
    if (conv_clock_config.async_clock_enable) begin
      in_tick = async_clk_tick;
    end else if (conv_clock_config.input_clock_select) begin
      in_tick = 1'b1;
    end else begin
      in_tick = alt_clk_tick;
    end
  end

  // generator runs only while a conversion is under way, to save power
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      async_gen_enable <= 1'b0;
    end else begin
      async_gen_enable <= conv_clock_config.async_clock_enable && (sar_busy || start);
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      low_power_config <= 1'b0;
    end else begin
      low_power_config <= conv_clock_config.low_power_config;
    end
  end

  adcrc_clkdiv u_clkdiv (
    .clock              (clock),
    .resetn             (resetn),
    .run                (sar_busy),
    .in_tick            (in_tick),
    .clock_divide_ratio (conv_clock_config.clock_divide_ratio),
    .conv_tick          (conv_tick)
  );

  adcrc_sar u_sar (
    .clock              (clock),
    .resetn             (resetn),
    .start              (start),
    .abort              (abort),
    .conv_tick          (conv_tick),
    .long_sample_select (conv_clock_config.long_sample_select),
    .comp_above         (comp_above),
    .dac_code           (dac_code),
    .sample_enable      (sample_enable),
    .busy               (sar_busy),
    .done               (sar_done),
    .raw                (sar_raw)
  );

  // result transfer
  assign rounded  = round_result(sar_raw, mode_10bit);
  assign transfer = sar_done && !(mode_10bit && interlock);

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      result <= 16'h0000;
    end else if (transfer) begin
      // writes to these addresses never reach here
      if (mode_10bit) begin
        result.high <= {6'h00, rounded[9:8]};
      end else begin
        result.high <= 8'h00;
      end
      result.low <= rounded[7:0];
    end
  end

  // interlock only exists in 10-bit modes
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      interlock <= 1'b0;
    end else if (!mode_10bit) begin
      interlock <= 1'b0;
    end else if (rd_high) begin
      interlock <= 1'b1;
    end else if (rd_low) begin
      interlock <= 1'b0;
    end
  end

  // completion wins over a clear in the same cycle
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      conversion_done_flag <= 1'b0;
    end else if (transfer) begin
      conversion_done_flag <= 1'b1;
    end else if (wr_status || rd_low) begin
      conversion_done_flag <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      conv_irq <= 1'b0;
    end else if (transfer && ctrl.conv_irq_enable) begin
      conv_irq <= 1'b1;
    end else if (wr_status || rd_low || rd_high || !ctrl.conv_irq_enable) begin
      conv_irq <= 1'b0;
    end
  end

endmodule

// file: dv/adcrc_top_asserts.sv
// Purpose: port-level checks of the converter control block
// Assumes: single bus clock, resetn active low
// Notes:   config-dependent rules live in the bench, config is not visible here
`timescale 1ns/1ps
`include "adcrc_map.svh"

module adcrc_top_asserts (
  input wire logic        clock,
  input wire logic        resetn,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        stop_mode,
  input wire logic        low_power_config,
  input wire logic        sample_enable,
  input wire logic        conv_irq
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  sequence taken_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence wr_s(logic [7:0] a);
    taken_s ##0 (wb_we_i && wb_adr_i == a && wb_sel_i[0]);
  endsequence

  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_latency_a: assert property (taken_s |=> wb_ack_o)
    else $error("ack not one cycle after request");
  upper_zero_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("unused read bits not zero");
  data_hold_a: assert property (!(wb_cyc_i && wb_stb_i) |=> $stable(wb_dat_o))
    else $error("read data moved without access");
  unmapped_a: assert property (taken_s ##0 (!wb_we_i && wb_adr_i > 8'h0C) |=> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  // the pin copy sits one register behind the config register
  low_power_a: assert property (wr_s(`ADCRC_OFS_CLK_CFG) |-> ##2
    low_power_config == $past(wb_dat_i[7], 2)) else $error("low power bit not copied");
  sample_len_a: assert property ($rose(sample_enable) |->
    (sample_enable || stop_mode)[*4]) else $error("sample phase too short");
  irq_clear_a: assert property (wr_s(`ADCRC_OFS_STATUS) ##0 wb_dat_i[4:0] == 5'h1F
    |=> !conv_irq) else $error("irq kept after status write");
endmodule

// file: dv/tb_top.sv
// Purpose: register-level test of the converter control block
// Assumes: comparator modelled as level >= dac_code, bus clock 25 MHz
// Notes:   done is polled over the bus, so timing checks are coarse ratios
`timescale 1ns/1ps
`include "adcrc_map.svh"
`define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin fail_count++; \
  $display("unexpected %s expected %h seen %h", nm, exp, got); end end

module tb_top;
  logic        clock, resetn, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, comp_above, got;
  logic        ext_trigger, stop_mode, alt_clk_tick, async_clk_tick, alt_run;
  logic        async_gen_enable, low_power_config, sample_enable, conv_irq;
  logic [7:0]  wb_adr_i, q;
  logic [3:0]  wb_sel_i, tick_cnt;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [10:0] dac_code, level;
  logic [4:0]  channel_select;
  int          fail_count, checked, samp_n, n, s0, s1, t[4];
  localparam logic [10:0] L1 = 11'h2D0;
  localparam logic [10:0] L2 = 11'h5A8;

  assign comp_above = (level >= dac_code);

  adcrc_top adcrc_top_i (.clock(clock), .resetn(resetn), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .comp_above(comp_above),
    .ext_trigger(ext_trigger), .stop_mode(stop_mode), .alt_clk_tick(alt_clk_tick),
    .async_clk_tick(async_clk_tick), .async_gen_enable(async_gen_enable),
    .low_power_config(low_power_config), .sample_enable(sample_enable), .dac_code(dac_code),
    .channel_select(channel_select), .conv_irq(conv_irq));

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  // slow clocks arrive as bus-cycle tick pulses
  always @(posedge clock) begin
    tick_cnt <= tick_cnt + 4'h1;
    alt_clk_tick <= alt_run && (tick_cnt[1:0] == 2'h0);
    async_clk_tick <= tick_cnt[0];
    if (sample_enable) samp_n <= samp_n + 1;
  end

  function automatic logic [9:0] r10(input logic [10:0] v);
    r10 = 10'(({1'b0, v} + 12'h1) >> 1);
  endfunction
  function automatic logic [7:0] r8(input logic [10:0] v);
    r8 = 8'(({1'b0, v} + 12'h4) >> 3);
  endfunction

  task automatic finish_test();
    if (fail_count == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int k;
    k = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= {24'h0, d};
    @(posedge clock);
    while (wb_ack_o !== 1'b1) begin
      k++;
      if (k > 16) begin
        fail_count++;
        finish_test();
      end
      @(posedge clock);
    end
    q = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clock);
  endtask

  task automatic poll(input int lim, output logic hit, output int cnt);
    hit = 1'b0;
    cnt = 0;
    while (!hit && cnt < lim) begin
      wb(1'b0, `ADCRC_OFS_STATUS, 8'h00);
      hit = q[7];
      cnt++;
    end
  endtask

  task automatic conv(input logic [7:0] cfg, input logic [10:0] lv, input logic [7:0] st,
                      input logic exp);
    level <= lv;
    wb(1'b1, `ADCRC_OFS_CLK_CFG, cfg);
    wb(1'b1, `ADCRC_OFS_STATUS, st);
    poll(exp ? 200 : 15, got, n);
    `CHK("done flag", exp, got)
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    wb(1'b0, a, 8'h00);
    `CHK("read data", exp, q)
  endtask

  initial begin
    {resetn, wb_cyc_i, wb_stb_i, wb_we_i, ext_trigger, stop_mode, alt_run} = '0;
    {alt_clk_tick, async_clk_tick, tick_cnt, wb_adr_i, wb_dat_i} = '0;
    wb_sel_i = 4'h1;
    level = L1;
    {fail_count, checked, samp_n} = '0;
    repeat (8) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    `CHK("channel out", 5'h1F, channel_select)
    rd(`ADCRC_OFS_STATUS, `ADCRC_STATUS_RESET);
    rd(`ADCRC_OFS_CLK_CFG, `ADCRC_CLK_CFG_RESET);
    rd(8'h10, 8'h00);
    conv(8'h10, L1, 8'h40, 1'b1);
    `CHK("irq", 1'b1, conv_irq)
    rd(`ADCRC_OFS_RES_HIGH, 8'h00);
    rd(`ADCRC_OFS_RES_LOW, r8(L1));
    `CHK("irq", 1'b0, conv_irq)
    poll(1, got, n);
    `CHK("done after low read", 1'b0, got)
    conv(8'h10, L2, 8'h00, 1'b1);
    rd(`ADCRC_OFS_RES_HIGH, 8'h00);
    conv(8'h10, L1, 8'h00, 1'b1);
    rd(`ADCRC_OFS_RES_LOW, r8(L1));
    wb(1'b1, `ADCRC_OFS_RES_HIGH, 8'hFF);
    wb(1'b1, `ADCRC_OFS_RES_LOW, 8'hFF);
    rd(`ADCRC_OFS_RES_LOW, r8(L1));
    // continuous run stopped by a config write, its running conversion aborted by a status write before done
    wb(1'b1, `ADCRC_OFS_STATUS, 8'h20);
    wb(1'b1, `ADCRC_OFS_CLK_CFG, 8'h10);
    wb(1'b0, `ADCRC_OFS_STATUS, 8'h00);
    `CHK("continuous bit", 1'b0, q[5])
    wb(1'b1, `ADCRC_OFS_STATUS, 8'h1F);
    poll(1, got, n);
    `CHK("done after status write", 1'b0, got)
    conv(8'h14, L1, 8'h00, 1'b1);
    rd(`ADCRC_OFS_RES_HIGH, {6'h0, r10(L1)[9:8]});
    conv(8'h14, L2, 8'h00, 1'b0);
    rd(`ADCRC_OFS_RES_LOW, r10(L1)[7:0]);
    conv(8'h14, L2, 8'h00, 1'b1);
    rd(`ADCRC_OFS_RES_HIGH, {6'h0, r10(L2)[9:8]});
    rd(`ADCRC_OFS_RES_LOW, r10(L2)[7:0]);
    for (int k = 0; k < 4; k++) begin
      wb(1'b1, `ADCRC_OFS_CLK_CFG, {1'b0, 2'(k), 5'h10});
      wb(1'b1, `ADCRC_OFS_STATUS, 8'h00);
      poll(400, got, t[k]);
      if (k > 0) `CHK("divided time", 1'b1, t[k] > t[k-1] + t[k-1] / 2)
    end
    s0 = samp_n;
    conv(8'h10, L1, 8'h00, 1'b1);
    s1 = samp_n;
    conv(8'h12, L1, 8'h00, 1'b1);
    `CHK("long minus short", 20, (samp_n - s1) - (s1 - s0))
    conv(8'h00, L2, 8'h00, 1'b0);
    alt_run <= 1'b1;
    poll(200, got, n);
    `CHK("alt clock done", 1'b1, got)
    rd(`ADCRC_OFS_RES_LOW, r8(L2));
    alt_run <= 1'b0;
    stop_mode <= 1'b1;
    wb(1'b1, `ADCRC_OFS_CLK_CFG, 8'h11);
    wb(1'b1, `ADCRC_OFS_STATUS, 8'h00);
    `CHK("async gen on", 1'b1, async_gen_enable)
    poll(200, got, n);
    `CHK("stop done", 1'b1, got)
    `CHK("async gen off", 1'b0, async_gen_enable)
    stop_mode <= 1'b0;
    wb(1'b1, `ADCRC_OFS_CLK_CFG, 8'h10);
    wb(1'b1, `ADCRC_OFS_STATUS, 8'h00);
    stop_mode <= 1'b1;
    poll(15, got, n);
    `CHK("stop abort", 1'b0, got)
    stop_mode <= 1'b0;
    conv(8'h18, L1, 8'h00, 1'b0);
    conv(8'h1C, L2, 8'h00, 1'b0);
    ext_trigger <= 1'b1;
    @(posedge clock);
    ext_trigger <= 1'b0;
    poll(200, got, n);
    `CHK("trigger done", 1'b1, got)
    rd(`ADCRC_OFS_RES_HIGH, {6'h0, r10(L2)[9:8]});
    rd(`ADCRC_OFS_RES_LOW, r10(L2)[7:0]);
    wb(1'b1, `ADCRC_OFS_CLK_CFG, 8'h90);
    `CHK("low power out", 1'b1, low_power_config)
    wb(1'b1, `ADCRC_OFS_STATUS, 8'h1F);
    finish_test();
  end
endmodule

bind adcrc_top adcrc_top_asserts adcrc_top_asserts_i (.clock(clock), .resetn(resetn),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .stop_mode(stop_mode), .low_power_config(low_power_config),
  .sample_enable(sample_enable), .conv_irq(conv_irq));
